// ==== core/ccs_gate.sv ====
// Runt-free source switch and enable gate for one global clock network.
`timescale 1ns/1ps
module ccs_gate
  import ccs_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      rst,
  input  wire logic      ce,
  input  wire ccs_cand_s cand,
  input  wire ccs_mode_e mode,
  input  wire logic [1:0] dyn_sel,
  input  wire logic      enable,
  input  wire logic      present,
  output logic           net_ff
);

  logic [2:0] sel_ff;
  logic       en_ff;
  logic [2:0] want_sel;
  logic       chosen;
  logic       safe;
  logic       nxt_net;

  // Dynamic select only steers between the two pins and two PLL outputs.
  assign want_sel = (mode == CCS_MODE_DUAL)     ? 3'h4 :
                    (mode == CCS_MODE_INTERNAL) ? 3'h5 : {1'b0, dyn_sel};  // R5 R6
  assign chosen   = (sel_ff == 3'h5) ? cand.intl  :
                    (sel_ff == 3'h4) ? cand.dual  :
                    (sel_ff == 3'h3) ? cand.pll_b :
                    (sel_ff == 3'h2) ? cand.pll_a :
                    (sel_ff == 3'h1) ? cand.ded_b : cand.ded_a;
  // New choices are adopted only while the network is low, so no short pulse escapes.
  assign safe     = ~net_ff;  // R18
  assign nxt_net  = en_ff & present & chosen;  // R7 R18

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sel_ff <= 3'h0;
      en_ff  <= 1'b0;
      net_ff <= 1'b0;
    end else if (ce) begin
      if (safe) begin
        sel_ff <= want_sel;
        en_ff  <= enable;
      end
      net_ff <= nxt_net;
    end
  end

  a_gate_low_off: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && !en_ff) |=> !net_ff) else $error("network high while gated off"); // R18
  a_gate_sel_hold: assert property (@(posedge ref_clk) disable iff (rst)
    $past(net_ff) && $past(ce) |-> $stable(sel_ff)) else $error("source changed while high"); // R18

endmodule : ccs_gate

// ==== core/ccs_pkg.sv ====
// Shared constants, types and register map of the global clock source selection block.
package ccs_pkg;

  localparam int NUM_NET      = 16;  // one control block per global network
  localparam int NUM_SIDE     = 4;   // left, top, right, bottom
  localparam int NET_PER_SIDE = 4;
  localparam int NUM_DED      = 16;  // dedicated clock pins, four per side
  localparam int NUM_DP       = 20;  // dual-purpose clock pins
  localparam int NUM_DP_DIR   = 12;  // directly connected, three per side; only the first two of each side reach a block
  localparam int DP_DIR_SIDE  = 3;
  localparam int NUM_CORNER   = 4;
  localparam int NUM_PLL      = 4;
  localparam int PLL_OUTS     = 3;
  localparam int NUM_INT      = 16;  // internal signals, four per side
  localparam int NUM_REGION   = 8;   // four row and four column I/O regions
  localparam int NUM_ROW_REG  = 4;
  localparam int BUS_W        = 6;   // clocks per region bus
  localparam int NUM_CLUSTER  = 4;
  localparam int CLUS_CLKS    = 2;
  localparam int DLY_DEPTH    = 3;   // stages of the dual-purpose delay chain
  localparam int PIN_W        = NUM_DED + NUM_DP + NUM_PLL * PLL_OUTS;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_DLY_LO    = 8'h08;
  localparam logic [7:0] ADDR_DLY_HI    = 8'h0C;
  localparam logic [7:0] ADDR_CLUSTER   = 8'h10;
  localparam logic [7:0] ADDR_BLK_BASE  = 8'h40;  // 16 words
  localparam logic [7:0] ADDR_REG_BASE  = 8'h80;  // 8 words
  localparam logic [7:0] ADDR_REG_LIMIT = 8'hA0;
  localparam int         WORD_LSB       = 2;

  // Control register fields.
  localparam int CTRL_USER   = 0;
  localparam int CTRL_SMALL  = 1;
  localparam int CTRL_MANUAL = 2;   // four bits
  localparam int CTRL_STATSW = 6;   // four bits
  localparam int CTRL_CORNER = 10;  // four bits
  localparam int SEL_W       = 4;   // width of a network index in a region field
  localparam int CSEL_W      = 3;   // width of a row clock index in a cluster field

  typedef enum logic [1:0] {
    CCS_MODE_DYNAMIC  = 2'h0,
    CCS_MODE_DUAL     = 2'h1,
    CCS_MODE_INTERNAL = 2'h3
  } ccs_mode_e;

  // Per-block static routing, one register word each.
  typedef struct packed {
    ccs_mode_e  mode;
    logic [1:0] int_idx;
    logic [1:0] dp_idx;
    logic [1:0] pll_b;
    logic [1:0] pll_a;
    logic [1:0] ded_b;
    logic [1:0] ded_a;
  } ccs_blk_cfg_s;

  // Six candidate inputs of one block, in dynamic select order then static.
  typedef struct packed {
    logic intl;
    logic dual;
    logic pll_b;
    logic pll_a;
    logic ded_b;
    logic ded_a;
  } ccs_cand_s;

  localparam ccs_blk_cfg_s BLK_CFG_RST = '0;

endpackage : ccs_pkg

// ==== core/ccs_top.sv ====
// Global clock control blocks, pin conditioning, region fan-out and APB registers.
// Summary of operation
// R1: One control block per network, sixteen maximum.
// R2: Large has sixteen blocks; small only left/right.
// R3: Candidates: pins, PLL outputs, dual pins, internals.
// R4: Six inputs reach each block.
// R5: Two-bit select picks pins or PLL outputs.
// R6: Dual-pin and internal choice fixed by configuration.
// R7: Network passes source only while enabled.
// R8: Switchover control steers the PLL reference mux.
// R9: One corner pin per corner feeds blocks.
// R10: Corner pins pass an extra mux stage.
// R11: Dedicated pins: sixteen large, eight small.
// R12: Unused dedicated pins feed logic through registers.
// R13: Dual-purpose pins: twenty large, eight small.
// R14: Each dual pin has a programmable delay.
// R15: Networks muxed into six-bit region buses.
// R16: Each cluster picks two of six row clocks.
// R17: Each I/O region receives only six clocks.
// R18: Disabled network low; switching makes no runts.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module ccs_top
  import ccs_pkg::*;
(
  input  wire logic                              ref_clk,
  input  wire logic                              rst,
  input  wire logic                              ce,
  input  wire logic [7:0]                        paddr,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [31:0]                       pwdata,
  output logic [31:0]                            prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic [NUM_DED-1:0]                ded_clk_pin,
  input  wire logic [NUM_DP-1:0]                 dual_purpose_clock_pin,
  input  wire logic [NUM_PLL*PLL_OUTS-1:0]       pll_clk,
  input  wire logic [NUM_INT-1:0]                internal_sig,
  input  wire logic [NUM_NET-1:0][1:0]           network_source_select,
  input  wire logic [NUM_NET-1:0]                network_enable,
  input  wire logic [NUM_PLL-1:0]                pll_reference_switchover,
  output logic [NUM_NET-1:0]                     global_clock_network,
  output logic [NUM_PLL-1:0]                     pll_ref_clk,
  output logic [NUM_DED-1:0]                     fabric_pin_data,
  output logic [NUM_REGION-1:0][BUS_W-1:0]       region_clk,
  output logic [NUM_CLUSTER-1:0][CLUS_CLKS-1:0]  cluster_clk
);

  // Picks one of four candidates by a two-bit index.
  function automatic logic pick4(input logic [3:0] v, input logic [1:0] i);
    pick4 = v[i];
  endfunction : pick4

  // Picks one of three PLL outputs; the unused code falls back to the first.
  function automatic logic pick3(input logic [2:0] v, input logic [1:0] i);
    pick3 = (i == 2'h3) ? v[0] : v[i];
  endfunction : pick3

  // ---------------- Registers ----------------
  logic [13:0]                          ctrl_ff;
  ccs_blk_cfg_s [NUM_NET-1:0]           blk_cfg_ff;
  logic [2*NUM_DP-1:0]                  dly_ff;
  logic [NUM_REGION-1:0][BUS_W*SEL_W-1:0] reg_sel_ff;
  logic [NUM_CLUSTER*CLUS_CLKS*CSEL_W-1:0] clus_sel_ff;
  logic                                 pready_ff;
  logic                                 pslverr_ff;
  logic [31:0]                          prdata_ff;

  wire user_mode = ctrl_ff[CTRL_USER];
  wire small_dev = ctrl_ff[CTRL_SMALL];
  wire [3:0] manual_en = ctrl_ff[CTRL_MANUAL +: NUM_PLL];
  wire [3:0] static_sw = ctrl_ff[CTRL_STATSW +: NUM_PLL];
  wire [3:0] corner_sel = ctrl_ff[CTRL_CORNER +: NUM_CORNER];

  // APB decode; the answer comes one cycle into the access phase.
  wire       access  = psel & penable;
  wire       nxt_pready = access & ~pready_ff;
  wire       commit  = access & pready_ff;
  wire [5:0] word    = paddr[7:WORD_LSB];
  wire       hit_ctrl = (paddr == ADDR_CTRL);
  wire       hit_stat = (paddr == ADDR_STATUS);
  wire       hit_dlo  = (paddr == ADDR_DLY_LO);
  wire       hit_dhi  = (paddr == ADDR_DLY_HI);
  wire       hit_clus = (paddr == ADDR_CLUSTER);
  wire       hit_blk  = (paddr >= ADDR_BLK_BASE) && (paddr < ADDR_REG_BASE);
  wire       hit_reg  = (paddr >= ADDR_REG_BASE) && (paddr < ADDR_REG_LIMIT);
  wire [3:0] blk_idx  = word[3:0];
  wire [2:0] reg_idx  = word[2:0];
  wire       aligned  = (paddr[1:0] == 2'h0);
  wire       mapped   = aligned & (hit_ctrl | hit_stat | hit_dlo | hit_dhi | hit_clus
                                   | hit_blk | hit_reg);
  // Static routing is frozen once user mode is entered; status is read-only.
  wire       locked   = pwrite & (user_mode | hit_stat);  // R6
  wire       nxt_err  = ~mapped | locked;
  wire       wr_ok    = commit & pwrite & ~pslverr_ff;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (hit_ctrl)      rd_mux = {18'h0, ctrl_ff};
    else if (hit_stat) rd_mux = {16'h0, global_clock_network};
    else if (hit_dlo)  rd_mux = dly_ff[31:0];
    else if (hit_dhi)  rd_mux = {24'h0, dly_ff[2*NUM_DP-1:32]};
    else if (hit_clus) rd_mux = {8'h0, clus_sel_ff};
    else if (hit_blk)  rd_mux = {18'h0, blk_cfg_ff[blk_idx]};
    else if (hit_reg)  rd_mux = {8'h0, reg_sel_ff[reg_idx]};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else if (ce) begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pready & nxt_err;
      prdata_ff  <= (nxt_pready & ~pwrite & mapped) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_ff     <= 14'h0;
      blk_cfg_ff  <= {NUM_NET{BLK_CFG_RST}};
      dly_ff      <= '0;
      reg_sel_ff  <= '0;
      clus_sel_ff <= '0;
    end else if (ce && wr_ok) begin
      if (hit_ctrl) ctrl_ff <= pwdata[13:0];
      if (hit_dlo)  dly_ff[31:0] <= pwdata;
      if (hit_dhi)  dly_ff[2*NUM_DP-1:32] <= pwdata[7:0];
      if (hit_clus) clus_sel_ff <= pwdata[23:0];
      if (hit_blk)  blk_cfg_ff[blk_idx] <= ccs_blk_cfg_s'(pwdata[13:0]);  // R6
      if (hit_reg)  reg_sel_ff[reg_idx] <= pwdata[23:0];
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // ---------------- Pin conditioning ----------------
  logic [PIN_W-1:0] pin_meta_ff;
  logic [PIN_W-1:0] pin_sync_ff;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else if (ce) begin
      pin_meta_ff <= {pll_clk, dual_purpose_clock_pin, ded_clk_pin};
      pin_sync_ff <= pin_meta_ff;
    end
  end
  wire [NUM_DED-1:0]          ded_s = pin_sync_ff[NUM_DED-1:0];
  wire [NUM_DP-1:0]           dp_s  = pin_sync_ff[NUM_DED +: NUM_DP];
  wire [NUM_PLL*PLL_OUTS-1:0] pll_s = pin_sync_ff[NUM_DED+NUM_DP +: NUM_PLL*PLL_OUTS];

  // Every dedicated pin, claimed by a network or not, is captured in ordinary logic registers.
  logic [NUM_DED-1:0] fabric_ff;
  always_ff @(posedge ref_clk) begin
    if (rst) fabric_ff <= '0;
    else if (ce) fabric_ff <= ded_s;  // R12
  end
  assign fabric_pin_data = fabric_ff;

  // Delay chain per dual-purpose pin; the tap is set by software before user mode.
  logic [NUM_DP-1:0][DLY_DEPTH-1:0] chain_ff;
  logic [NUM_DP-1:0]                dp_dly;
  for (genvar p = 0; p < NUM_DP; p++) begin : g_dly
    wire [1:0] tap = dly_ff[2*p +: 2];
    always_ff @(posedge ref_clk) begin
      if (rst) chain_ff[p] <= '0;
      else if (ce) chain_ff[p] <= {chain_ff[p][DLY_DEPTH-2:0], dp_s[p]};
    end
    assign dp_dly[p] = pick4({chain_ff[p], dp_s[p]}, tap);  // R14
  end

  // Corner pins share one block input per corner through an extra register stage,
  // so they arrive one cycle later than directly connected pins.
  logic [NUM_CORNER-1:0] corner_ff;
  for (genvar c = 0; c < NUM_CORNER; c++) begin : g_corner
    wire pick = corner_sel[c] ? dp_dly[NUM_DP_DIR+2*c+1] : dp_dly[NUM_DP_DIR+2*c];  // R9
    always_ff @(posedge ref_clk) begin
      if (rst) corner_ff[c] <= 1'b0;
      else if (ce) corner_ff[c] <= pick;  // R10
    end
  end

  // ---------------- PLL reference multiplexers ----------------
  logic [NUM_PLL-1:0] pll_ref_ff;
  for (genvar p = 0; p < NUM_PLL; p++) begin : g_pllref
    wire sw = manual_en[p] ? pll_reference_switchover[p] : static_sw[p];  // R8
    always_ff @(posedge ref_clk) begin
      if (rst) pll_ref_ff[p] <= 1'b0;
      else if (ce) pll_ref_ff[p] <= sw ? ded_s[NET_PER_SIDE*p+1] : ded_s[NET_PER_SIDE*p];  // R8
    end
  end
  assign pll_ref_clk = pll_ref_ff;

  // ---------------- Clock control blocks ----------------
  logic [NUM_NET-1:0] net;
  for (genvar n = 0; n < NUM_NET; n++) begin : g_blk  // R1
    localparam int S = n / NET_PER_SIDE;
    ccs_blk_cfg_s cfg;
    ccs_cand_s    cand;
    wire [3:0] ded_side = ded_s[NET_PER_SIDE*S +: NET_PER_SIDE];  // R3 R11
    wire [2:0] pll_side = pll_s[PLL_OUTS*S +: PLL_OUTS];
    wire [3:0] dp_side  = {corner_ff[(S+1)%NUM_CORNER], corner_ff[S],
                           dp_dly[DP_DIR_SIDE*S+1], dp_dly[DP_DIR_SIDE*S]};  // R13
    wire [3:0] int_side = internal_sig[NET_PER_SIDE*S +: NET_PER_SIDE];
    // The small variant keeps only the left and right blocks.
    wire present = ~(small_dev & S[0]);  // R2
    assign cfg = blk_cfg_ff[n];
    assign cand.ded_a = pick4(ded_side, cfg.ded_a);  // R4
    assign cand.ded_b = pick4(ded_side, cfg.ded_b);
    assign cand.pll_a = pick3(pll_side, cfg.pll_a);
    assign cand.pll_b = pick3(pll_side, cfg.pll_b);
    assign cand.dual  = pick4(dp_side, cfg.dp_idx);
    assign cand.intl  = pick4(int_side, cfg.int_idx);
    ccs_gate u_gate (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .cand    (cand),
      .mode    (cfg.mode),
      .dyn_sel (network_source_select[n]),  // R5
      .enable  (network_enable[n]),  // R7
      .present (present),
      .net_ff  (net[n])
    );
  end
  assign global_clock_network = net;

  // ---------------- Region and cluster fan-out ----------------
  logic [NUM_REGION-1:0][BUS_W-1:0]      region_ff;
  logic [NUM_CLUSTER-1:0][CLUS_CLKS-1:0] cluster_ff;
  for (genvar r = 0; r < NUM_REGION; r++) begin : g_region
    for (genvar j = 0; j < BUS_W; j++) begin : g_bit
      wire [3:0] s = reg_sel_ff[r][SEL_W*j +: SEL_W];
      always_ff @(posedge ref_clk) begin
        if (rst) region_ff[r][j] <= 1'b0;
        else if (ce) region_ff[r][j] <= net[s];  // R15 R17
      end
    end
  end
  for (genvar c = 0; c < NUM_CLUSTER; c++) begin : g_clus
    for (genvar k = 0; k < CLUS_CLKS; k++) begin : g_clk
      wire [2:0] s = clus_sel_ff[CSEL_W*(CLUS_CLKS*c+k) +: CSEL_W];
      wire       v = (s < 3'(BUS_W)) ? region_ff[c % NUM_ROW_REG][s] : 1'b0;
      always_ff @(posedge ref_clk) begin
        if (rst) cluster_ff[c][k] <= 1'b0;
        else if (ce) cluster_ff[c][k] <= v;  // R16
      end
    end
  end
  assign region_clk  = region_ff;
  assign cluster_clk = cluster_ff;

  // ---------------- Assertions ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_apb_one_wait: assert property ($rose(psel & penable) && ce |=> pready_ff)
    else $error("APB answer not one cycle late");
  a_cfg_locked: assert property (user_mode && ce |=> $stable(blk_cfg_ff)) // R6
    else $error("static routing changed in user mode");
  a_small_off: assert property (small_dev && ce ##1 ce |=> !net[4] && !net[12]) // R2
    else $error("top or bottom network active on small variant");
  a_net_pass: assert property (ce && g_blk[0].u_gate.en_ff && g_blk[0].present // R7
      && g_blk[0].u_gate.sel_ff == 3'h0 |=> net[0] == $past(ded_s[blk_cfg_ff[0].ded_a]))
    else $error("enabled network does not follow source");
  a_corner_late: assert property (ce && !corner_sel[0] |=> corner_ff[0] == $past(dp_dly[12])) // R10
    else $error("corner stage wrong");
  a_pll_ref: assert property (ce && !manual_en[0] && !static_sw[0] // R8
      |=> pll_ref_clk[0] == $past(ded_s[0])) else $error("PLL reference mux wrong");
  a_dly_tap: assert property (ce [*3] ##1 dly_ff[1:0] == 2'h3 // R14
      |-> dp_dly[0] == $past(dp_s[0], 3)) else $error("delay tap three not three cycles");
  a_region_map: assert property (ce |=> region_clk[0][0] == $past(net[reg_sel_ff[0][3:0]])) // R15
    else $error("region bus select wrong");
  a_fabric_cap: assert property (ce |=> fabric_pin_data == $past(ded_s)) // R12
    else $error("fabric capture wrong");

  c_user_mode: cover property ($rose(user_mode));
  c_net_toggle: cover property (net[0] ##1 !net[0] ##1 net[0]);
  c_dyn_switch: cover property ($changed(g_blk[0].u_gate.sel_ff));
  c_err_resp: cover property (pready_ff && pslverr_ff);

endmodule : ccs_top

// ==== verification/ccs_top_tb.sv ====
// Self-checking testbench for the global clock source selection block.
`timescale 1ns/1ps
module ccs_top_tb
  import ccs_pkg::*;
;
  logic                                 ref_clk = 1'b0;
  logic                                 rst     = 1'b1;
  logic                                 ce      = 1'b1;
  logic [7:0]                           paddr   = '0;
  logic                                 psel    = 1'b0;
  logic                                 penable = 1'b0;
  logic                                 pwrite  = 1'b0;
  logic [31:0]                          pwdata  = '0;
  logic [31:0]                          prdata;
  logic                                 pready;
  logic                                 pslverr;
  logic [NUM_DED-1:0]                   ded_pin = '0;
  logic [NUM_DP-1:0]                    dp_pin  = '0;
  logic [NUM_PLL*PLL_OUTS-1:0]          pll_clk = '0;
  logic [NUM_INT-1:0]                   int_sig = '0;
  logic [NUM_NET-1:0][1:0]              net_sel;
  logic [NUM_NET-1:0]                   net_en;
  logic [NUM_PLL-1:0]                   pll_sw;
  logic [NUM_NET-1:0]                   gnet;
  logic [NUM_PLL-1:0]                   pll_ref;
  logic [NUM_DED-1:0]                   fabric;
  logic [NUM_REGION-1:0][BUS_W-1:0]     region_clk;
  logic [NUM_CLUSTER-1:0][CLUS_CLKS-1:0] cluster_clk;
  wire  [49:0]                          obs = {cluster_clk, region_clk[0], pll_ref, fabric, gnet};
  int                                   fails     = 0;
  int                                   cmp_count = 0;

  always #20 ref_clk = ~ref_clk;

  ccs_user_model user_u (.ref_clk(ref_clk), .network_source_select(net_sel),
    .network_enable(net_en), .pll_reference_switchover(pll_sw));

  ccs_top dut_u (.ref_clk(ref_clk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ded_clk_pin(ded_pin), .dual_purpose_clock_pin(dp_pin),
    .pll_clk(pll_clk), .internal_sig(int_sig), .network_source_select(net_sel),
    .network_enable(net_en), .pll_reference_switchover(pll_sw),
    .global_clock_network(gnet), .pll_ref_clk(pll_ref), .fabric_pin_data(fabric),
    .region_clk(region_clk), .cluster_clk(cluster_clk));

  task automatic stop_test;
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) chk("pready", 1, 0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    chk("write_error", {31'h0, exp_err}, {31'h0, err});
  endtask : wr

  // Waits up to twelve cycles for the level, then six more cycles, and checks it once at the end.
  task automatic settle(input string name, input int idx, input logic exp);
    int n;
    n = 0;
    while (obs[idx] !== exp && n < 12) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (6) @(posedge ref_clk);
    chk(name, {31'h0, exp}, {31'h0, obs[idx]});
  endtask : settle

  task automatic t_regs;
    logic [31:0] rd;
    logic        err;
    apb(1'b0, ADDR_CTRL, '0, rd, err);
    chk("ctrl_reset", 32'h0, rd);
    wr(ADDR_BLK_BASE, 32'h0000_0096, 1'b0);
    apb(1'b0, ADDR_BLK_BASE, '0, rd, err);
    chk("blk0_readback", 32'h0000_0096, rd);
    apb(1'b0, ADDR_REG_LIMIT, '0, rd, err);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    apb(1'b0, 8'h41, '0, rd, err);
    chk("unaligned_err", 32'h1, {31'h0, err});
    wr(ADDR_STATUS, 32'h0000_FFFF, 1'b1);
  endtask : t_regs

  task automatic t_config;
    wr(ADDR_BLK_BASE + 8'h04, 32'h0000_1000, 1'b0);
    wr(ADDR_BLK_BASE + 8'h08, 32'h0000_3C00, 1'b0);
    wr(ADDR_BLK_BASE + 8'h0C, 32'h0000_1200, 1'b0);
    wr(ADDR_DLY_LO, 32'h0000_0003, 1'b0);
    wr(ADDR_CLUSTER, 32'h0000_0038, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0085, 1'b0);
  endtask : t_config

  task automatic t_dynamic;
    int          src [4] = '{2, 1, 1, 2};
    logic [15:0] dm;
    logic [11:0] pm;
    logic [31:0] rd;
    logic        err;
    for (int s = 0; s < 4; s++) begin
      dm = (s < 2) ? (16'h1 << src[s]) : 16'h0;
      pm = (s >= 2) ? (12'h1 << src[s]) : 12'h0;
      @(posedge ref_clk);
      ded_pin <= '0;
      pll_clk <= '0;
      user_u.drive_net(0, s[1:0], 1'b1);
      settle("net0_idle", 0, 1'b0);
      ded_pin <= dm;
      pll_clk <= pm;
      settle("net0_selected", 0, 1'b1);
      @(posedge ref_clk);
      ded_pin <= ~dm;
      pll_clk <= ~pm;
      settle("net0_others", 0, 1'b0);
    end
    pll_clk <= 12'h004;
    settle("net0_on", 0, 1'b1);
    // A static high source never lets the gate adopt a change, so give it a low phase.
    user_u.drive_net(0, 2'h3, 1'b0);
    pll_clk <= 12'h000;
    settle("net0_gap", 0, 1'b0);
    pll_clk <= 12'h004;
    settle("net0_disabled", 0, 1'b0);
    user_u.drive_net(0, 2'h3, 1'b1);
    settle("net0_reenabled", 0, 1'b1);
    user_u.drive_net(4, 2'h0, 1'b1);
    settle("net4_large", 4, 1'b1);
    apb(1'b0, ADDR_STATUS, '0, rd, err);
    chk("status_net4", 32'h1, {31'h0, rd[4]});
  endtask : t_dynamic

  task automatic t_static;
    @(posedge ref_clk);
    dp_pin  <= '0;
    int_sig <= 16'h0001;
    for (int n = 1; n < 4; n++) user_u.drive_net(n, 2'h0, 1'b1);
    settle("dual_low", 1, 1'b0);
    settle("intl_low", 2, 1'b0);
    dp_pin[0]  <= 1'b1;
    int_sig[3] <= 1'b1;
    settle("dual_high", 1, 1'b1);
    settle("intl_high", 2, 1'b1);
    dp_pin[13] <= 1'b1;
    settle("corner_unpicked", 3, 1'b0);
    dp_pin[12] <= 1'b1;
    settle("corner_picked", 3, 1'b1);
    wr(ADDR_BLK_BASE + 8'h04, 32'h0000_3000, 1'b1);
    @(posedge ref_clk);
    dp_pin[0] <= 1'b0;
    settle("dual_locked", 1, 1'b0);
  endtask : t_static

  task automatic t_pll;
    @(posedge ref_clk);
    ded_pin <= 16'h0001;
    user_u.drive_switch(1, 1'b0);
    user_u.drive_switch(0, 1'b0);
    settle("ref0_primary", 32, 1'b1);
    user_u.drive_switch(0, 1'b1);
    settle("ref0_switched", 32, 1'b0);
    settle("ref1_static_off", 33, 1'b0);
    ded_pin <= 16'h0020;
    settle("ref1_static_on", 33, 1'b1);
  endtask : t_pll

  task automatic t_fanout;
    @(posedge ref_clk);
    pll_clk <= 12'h004;
    ded_pin <= 16'h0080;
    settle("region_first", 36, 1'b1);
    settle("region_last", 41, 1'b1);
    chk("region_col", 32'h3F, {26'h0, region_clk[7]});
    settle("cluster_pick", 42, 1'b1);
    settle("cluster_blank", 43, 1'b0);
    settle("fabric_high", 23, 1'b1);
    ce      <= 1'b0;
    ded_pin <= 16'h0000;
    pll_clk <= 12'h000;
    repeat (8) @(posedge ref_clk);
    chk("frozen_fabric", 32'h1, {31'h0, obs[23]});
    ce <= 1'b1;
    settle("region_low", 36, 1'b0);
    settle("fabric_low", 23, 1'b0);
  endtask : t_fanout

  task automatic t_small;
    logic [31:0] rd;
    logic        err;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    chk("net_reset", 32'h0, {16'h0, gnet});
    apb(1'b0, ADDR_CTRL, '0, rd, err);
    chk("ctrl_rereset", 32'h0, rd);
    wr(ADDR_CTRL, 32'h0000_0003, 1'b0);
    ded_pin <= '1;
    user_u.drive_net(0, 2'h0, 1'b1);
    settle("small_left", 0, 1'b1);
    settle("small_top_blank", 4, 1'b0);
  endtask : t_small

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_config();
    t_dynamic();
    t_static();
    t_pll();
    t_fanout();
    t_small();
    stop_test();
  end
endmodule : ccs_top_tb

// ==== verification/ccs_user_model.sv ====
// Behavioural user logic that steers network selects, enables and PLL switchover.
`timescale 1ns/1ps
module ccs_user_model
  import ccs_pkg::*;
(
  input  wire logic               ref_clk,
  output logic [NUM_NET-1:0][1:0] network_source_select,
  output logic [NUM_NET-1:0]      network_enable,
  output logic [NUM_PLL-1:0]      pll_reference_switchover
);
  initial begin
    network_source_select    = '0;
    network_enable           = '0;
    pll_reference_switchover = '0;
  end

  // Changes land just after an edge, as registered user logic would drive them.
  task automatic drive_net(input int n, input logic [1:0] sel, input logic en);
    @(posedge ref_clk);
    network_source_select[n] <= sel;
    network_enable[n]        <= en;
  endtask : drive_net

  task automatic drive_switch(input int p, input logic sw);
    @(posedge ref_clk);
    pll_reference_switchover[p] <= sw;
  endtask : drive_switch
endmodule : ccs_user_model
